// [logic/pmpd_map.vh]
// register map, field positions, reset values and presence straps for
// the partition/monitor feature page decoder.
// assumes byte addressing; offsets are byte offsets into a feature page.
`ifndef PMPD_MAP_VH
`define PMPD_MAP_VH

// page geometry: 4 KB aligned base, span of two 4 KB frames
`define PMPD_PAGE_SPAN      20'h00002
`define PMPD_OFF_W          13
`define PMPD_NS_BASE        32'h0002_0000
`define PMPD_S_BASE         32'h0005_0000

// register offsets within a feature page
`define PMPD_OFF_IDR        13'h0000
`define PMPD_OFF_SIDR       13'h0008
`define PMPD_OFF_CPOR_IDR   13'h0030
`define PMPD_OFF_MONITOR_REGS_IDR  13'h0080
`define PMPD_OFF_CSUMON_IDR 13'h0088
`define PMPD_OFF_PART_SEL   13'h0100
`define PMPD_OFF_MON_SEL    13'h0800
`define PMPD_OFF_CSU_CTL    13'h0810
`define PMPD_OFF_CSU_FLT    13'h0818
`define PMPD_OFF_CSU_CNT    13'h0840
`define PMPD_OFF_CPBM       13'h1000

// feature presence straps
`define PMPD_HAS_SECURE     1'b1
`define PMPD_HAS_CPOR       1'b1
`define PMPD_HAS_MONITOR_REGS      1'b1
`define PMPD_HAS_CSU        1'b1

// feature id and monitor control register fields
`define PMPD_IDR_PMG_LSB    16
`define PMPD_IDR_CPOR_BIT   25
`define PMPD_IDR_MONITOR_REGS_BIT  30
`define PMPD_MONITOR_REGS_CSU_BIT  16
`define PMPD_CTL_EN_BIT     31

// reported parameters
`define PMPD_PARTITION_IDENTIFIER_MAX     16'h000f
`define PMPD_PMG_MAX        8'h03
`define PMPD_S_PARTITION_IDENTIFIER_MAX   16'h000f
`define PMPD_S_PMG_MAX      8'h03
`define PMPD_CPBM_WD        16'h0010
`define PMPD_NUM_MON        16'h0004

// reset values
`define PMPD_PART_SEL_RST   4'h0
`define PMPD_MON_SEL_RST    2'h0
`define PMPD_CPBM_RST       16'hffff
`define PMPD_FLT_RST        4'h0
`define PMPD_CNT_RST        32'h0000_0000

`endif

// [logic/pmpd_bank.v]
// one security space's banked state: selectors, per-partition portion
// bitmaps and the cache-usage monitor instances.
// assumes wr_en is a one-cycle pulse with off and wdata stable.
`timescale 1ns/1ns
`include "pmpd_map.vh"

module pmpd_bank (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // register access from the page decoder
  input  wire        wr_en,
  input  wire [12:0] off,
  input  wire [31:0] wdata,
  output reg  [31:0] rdata,
  output reg         rhit,
  // usage events for this space
  input  wire        ev_valid,
  input  wire [3:0]  ev_partition_identifier,
  // resource control lookup
  input  wire [3:0]  lk_partition_identifier,
  output wire [15:0] lk_cpbm,
  // selector state
  output reg  [3:0]  part_sel_r,
  output reg  [1:0]  mon_sel_r
);

  reg [15:0] cpbm_r [0:15];   // portion bitmap per partition
  reg        en_r   [0:3];    // monitor enable
  reg [3:0]  flt_r  [0:3];    // monitor partition filter
  reg [31:0] cnt_r  [0:3];    // monitor count
  integer    i;

  assign lk_cpbm = cpbm_r[lk_partition_identifier];

  // writes go to the instance picked by the selectors
  always @(posedge clk) begin
    if (!rst_n) begin
      part_sel_r <= `PMPD_PART_SEL_RST;
      mon_sel_r  <= `PMPD_MON_SEL_RST;
      for (i = 0; i < 16; i = i + 1) begin
        cpbm_r[i] <= `PMPD_CPBM_RST;
      end
      for (i = 0; i < 4; i = i + 1) begin
        en_r[i]  <= 1'b0;
        flt_r[i] <= `PMPD_FLT_RST;
        cnt_r[i] <= `PMPD_CNT_RST;
      end
    end else begin
      // counting first so a software write of the count wins
      for (i = 0; i < 4; i = i + 1) begin
        if (ev_valid && en_r[i] && (ev_partition_identifier == flt_r[i])) begin
          cnt_r[i] <= cnt_r[i] + 32'h0000_0001;
        end
      end
      if (wr_en) begin
        case (off)
          `PMPD_OFF_PART_SEL: part_sel_r <= wdata[3:0];
          `PMPD_OFF_CPBM:     cpbm_r[part_sel_r] <= wdata[15:0];
          `PMPD_OFF_MON_SEL:  mon_sel_r <= wdata[1:0];
          `PMPD_OFF_CSU_CTL:
            en_r[mon_sel_r] <= wdata[`PMPD_CTL_EN_BIT];
          `PMPD_OFF_CSU_FLT:  flt_r[mon_sel_r] <= wdata[3:0];
          `PMPD_OFF_CSU_CNT:  cnt_r[mon_sel_r] <= wdata;
          default: ;
        endcase
      end
    end
  end

  // read side, same selection as the write side
  always @*  begin
    rdata = 32'h0000_0000;
    rhit  = 1'b1;
    case (off)
      `PMPD_OFF_PART_SEL: rdata = {28'h0000000, part_sel_r};
      `PMPD_OFF_CPBM:     rdata = {16'h0000, cpbm_r[part_sel_r]};
      `PMPD_OFF_MON_SEL:  rdata = {30'h00000000, mon_sel_r};
      `PMPD_OFF_CSU_CTL:  rdata = {en_r[mon_sel_r], 31'h00000000};
      `PMPD_OFF_CSU_FLT:  rdata = {28'h0000000, flt_r[mon_sel_r]};
      `PMPD_OFF_CSU_CNT:  rdata = cnt_r[mon_sel_r];
      default:            rhit  = 1'b0;
    endcase
  end

endmodule

// [logic/pmpd_page_decode.v]
// apb register slave decoding a secure and a non-secure feature page,
// holding the id registers and two banks of selector state.
// assumes an apb4 master on clk; pprot[1] carries the non-secure
// attribute; usage and lookup inputs come from logic on clk.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`include "pmpd_map.vh"

module pmpd_page_decode #(
  parameter [31:0] NS_PAGE_BASE = `PMPD_NS_BASE,
  parameter [31:0] S_PAGE_BASE  = `PMPD_S_BASE
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [2:0]  pprot,
  input  wire [3:0]  pstrb,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // usage events from the memory system
  input  wire        ev_valid,
  input  wire        ev_ns,
  input  wire [3:0]  ev_partition_identifier,
  // portion bitmap lookup for requests
  input  wire        lk_ns,
  input  wire [3:0]  lk_partition_identifier,
  output reg  [15:0] lk_cpbm,
  // selector state seen by the rest of the component
  output wire [3:0]  s_part_sel,
  output wire [3:0]  ns_part_sel,
  output wire [1:0]  s_mon_sel,
  output wire [1:0]  ns_mon_sel
);

  // page decode

  wire        acc_ns;      // access carries the non-secure attribute
  wire [19:0] ns_frame;    // 4 KB frame distance from non-secure base
  wire [19:0] s_frame;     // 4 KB frame distance from secure base
  wire        ns_in_blk;   // same 64 KB block as the non-secure base
  wire        s_in_blk;    // same 64 KB block as the secure base
  wire        ns_hit;      // address falls in the non-secure page
  wire        s_hit;       // address falls in the secure page
  wire        page_hit;    // either page
  wire [12:0] ns_off;      // byte offset into the non-secure page
  wire [12:0] s_off;       // byte offset into the secure page
  wire [12:0] off;         // offset of whichever page hit
  wire        aligned;     // word aligned access

  assign acc_ns = pprot[1];

  // base low 12 bits are ignored, so each page sits on 4 KB
  assign ns_frame = paddr[31:12] - NS_PAGE_BASE[31:12];
  assign s_frame  = paddr[31:12] - S_PAGE_BASE[31:12];

  // a page never spills out of the 64 KB block of its base
  assign ns_in_blk = (paddr[31:16] == NS_PAGE_BASE[31:16]);
  assign s_in_blk  = (paddr[31:16] == S_PAGE_BASE[31:16]);

  // each page is decoded by its own base and its own space
  assign ns_hit = acc_ns && ns_in_blk &&
                  (ns_frame < `PMPD_PAGE_SPAN);
  assign s_hit  = `PMPD_HAS_SECURE && !acc_ns && s_in_blk &&
                  (s_frame < `PMPD_PAGE_SPAN);

  assign page_hit = ns_hit || s_hit;

  // offset: low frame bit joined with the in-frame address
  assign ns_off  = {ns_frame[0], paddr[11:0]};
  assign s_off   = {s_frame[0], paddr[11:0]};
  assign off     = s_hit ? s_off : ns_off;
  assign aligned = (paddr[1:0] == 2'b00);

  // apb phases

  wire setup_ph;   // first cycle of a transfer
  wire access_ok;  // access phase that completes this edge
  wire full_word;  // all four byte lanes written
  wire wr_commit;  // write that takes effect this edge

  assign setup_ph  = psel && !penable;
  assign access_ok = psel && penable && pready;

  // a 32-bit word is written whole in one edge, never in pieces
  assign full_word = (pstrb == 4'hf);
  assign wr_commit = access_ok && pwrite && page_hit &&
                     aligned && full_word;

  // banked state, one bank per security space

  wire [31:0] s_bank_rdata;    // secure bank read value
  wire        s_bank_rhit;     // secure bank owns the offset
  wire [31:0] ns_bank_rdata;   // non-secure bank read value
  wire        ns_bank_rhit;    // non-secure bank owns the offset
  wire [15:0] s_lk_cpbm;       // secure bitmap for lookup partition
  wire [15:0] ns_lk_cpbm;      // non-secure bitmap for lookup partition
  wire        s_bank_wr;       // write strobe to the secure bank
  wire        ns_bank_wr;      // write strobe to the non-secure bank

  // writes land only in the bank of the page they came through
  assign s_bank_wr  = wr_commit && s_hit;
  assign ns_bank_wr = wr_commit && ns_hit;

  // secure selectors and secure partitions
  pmpd_bank u_s_bank (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_en      (s_bank_wr),
    .off        (off),
    .wdata      (pwdata),
    .rdata      (s_bank_rdata),
    .rhit       (s_bank_rhit),
    .ev_valid   (ev_valid && !ev_ns),
    .ev_partition_identifier  (ev_partition_identifier),
    .lk_partition_identifier  (lk_partition_identifier),
    .lk_cpbm    (s_lk_cpbm),
    .part_sel_r (s_part_sel),
    .mon_sel_r  (s_mon_sel)
  );

  // non-secure selectors and non-secure partitions
  pmpd_bank u_ns_bank (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_en      (ns_bank_wr),
    .off        (off),
    .wdata      (pwdata),
    .rdata      (ns_bank_rdata),
    .rhit       (ns_bank_rhit),
    .ev_valid   (ev_valid && ev_ns),
    .ev_partition_identifier  (ev_partition_identifier),
    .lk_partition_identifier  (lk_partition_identifier),
    .lk_cpbm    (ns_lk_cpbm),
    .part_sel_r (ns_part_sel),
    .mon_sel_r  (ns_mon_sel)
  );

  // identification register values

  wire [31:0] idr_val;      // main feature id
  wire [31:0] sidr_val;     // secure feature id
  wire [31:0] cpor_val;     // portion partitioning id
  wire [31:0] monitor_regs_val;    // monitor type list
  wire [31:0] csumon_val;   // usage monitor id

  // presence bits and largest partition and group accepted
  assign idr_val = {1'b0, `PMPD_HAS_MONITOR_REGS, 4'h0, `PMPD_HAS_CPOR,
                    1'b0, `PMPD_PMG_MAX, `PMPD_PARTITION_IDENTIFIER_MAX};

  // secure partition range, for the secure page only
  assign sidr_val = {8'h00, `PMPD_S_PMG_MAX, `PMPD_S_PARTITION_IDENTIFIER_MAX};

  // bitmap width of the portion control
  assign cpor_val = {16'h0000, `PMPD_CPBM_WD};

  // one bit per supported monitor type
  assign monitor_regs_val = {15'h0000, `PMPD_HAS_CSU, 16'h0000};

  // number of usage monitor instances
  assign csumon_val = {16'h0000, `PMPD_NUM_MON};

  // read value of the addressed location

  reg [31:0] rd_val;   // value returned for the current address

  // id registers first, then the bank of the page that hit
  always @* begin
    rd_val = 32'h0000_0000;
    if (page_hit && aligned) begin
      case (off)
        `PMPD_OFF_IDR: begin
          rd_val = idr_val;
        end
        `PMPD_OFF_SIDR: begin
          // invisible through the non-secure page
          if (s_hit) begin
            rd_val = sidr_val;
          end
        end
        `PMPD_OFF_CPOR_IDR: begin
          // only when the main id reports the control
          if (idr_val[`PMPD_IDR_CPOR_BIT]) begin
            rd_val = cpor_val;
          end
        end
        `PMPD_OFF_MONITOR_REGS_IDR: begin
          // only when the main id reports monitors
          if (idr_val[`PMPD_IDR_MONITOR_REGS_BIT]) begin
            rd_val = monitor_regs_val;
          end
        end
        `PMPD_OFF_CSUMON_IDR: begin
          // only when the monitor list names this type
          if (idr_val[`PMPD_IDR_MONITOR_REGS_BIT] &&
              monitor_regs_val[`PMPD_MONITOR_REGS_CSU_BIT]) begin
            rd_val = csumon_val;
          end
        end
        default: begin
          // selectors and selected instances of this space
          if (s_hit && s_bank_rhit) begin
            rd_val = s_bank_rdata;
          end else if (ns_hit && ns_bank_rhit) begin
            rd_val = ns_bank_rdata;
          end else begin
            rd_val = 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // apb answer: one access cycle, no waits

  // answer is prepared at the setup edge and shown in the access phase
  always @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup_ph) begin
      // whole word read in one sample; wider masters split upstream
      pready  <= 1'b1;
      pslverr <= !page_hit;
      prdata  <= pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      // release the answer after the completing edge
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // portion bitmap lookup

  // the request's space picks the bank, the partition picks the entry
  always @(posedge clk) begin
    if (!rst_n) begin
      lk_cpbm <= `PMPD_CPBM_RST;
    end else if (lk_ns) begin
      lk_cpbm <= ns_lk_cpbm;
    end else begin
      lk_cpbm <= s_lk_cpbm;
    end
  end

endmodule

// [dv/pmpd_page_decode_props.sv]
// concurrent checks on the apb side of the feature page decoder.
// assumes binding to the decoder top; sees its ports only.
`timescale 1ns/1ns

module pmpd_props_chk #(
  parameter [31:0] NS_PAGE_BASE = 32'h0002_0000,
  parameter [31:0] S_PAGE_BASE  = 32'h0005_0000
) (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // apb slave
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [2:0]  pprot,
  input wire [3:0]  pstrb,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // selectors
  input wire [3:0]  s_part_sel,
  input wire [3:0]  ns_part_sel,
  input wire [1:0]  s_mon_sel,
  input wire [1:0]  ns_mon_sel
);
  wire [31:0] ns_d   = paddr - NS_PAGE_BASE;  // offset into ns page
  wire [31:0] s_d    = paddr - S_PAGE_BASE;   // offset into s page
  wire        ns_hit = pprot[1] && (ns_d < 32'h2000);
  wire        s_hit  = !pprot[1] && (s_d < 32'h2000);
  wire        hit    = ns_hit || s_hit;
  wire [12:0] off    = ns_hit ? ns_d[12:0] : s_d[12:0];
  wire        setup  = psel && !penable;      // setup phase
  wire        rd_st  = setup && !pwrite;
  wire        wr_st  = setup && pwrite && (pstrb == 4'hf);
  wire        wr_end = psel && penable && pready && pwrite;
  wire [3:0]  wd4    = pwdata[3:0];
  wire [1:0]  wd2    = pwdata[1:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ready_after_setup_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  err_outside_a: assert property (setup && !hit |=> pslverr &&
    prdata == 32'h0) else $error("no error outside pages");
  err_inside_a: assert property (setup && hit |=> !pslverr)
    else $error("error inside a page");
  idr_value_a: assert property (rd_st && hit && off == 13'h0
    |=> prdata == 32'h4203000f) else $error("bad feature id");
  sidr_ns_a: assert property (rd_st && ns_hit && off == 13'h8
    |=> prdata == 32'h0) else $error("secure id seen from ns");
  sidr_s_a: assert property (rd_st && s_hit && off == 13'h8
    |=> prdata == 32'h0003000f) else $error("bad secure id");
  s_psel_wr_a: assert property (wr_st && s_hit && off == 13'h100
    ##1 pready |=> s_part_sel == $past(wd4) && $stable(ns_part_sel))
    else $error("secure partition select write");
  ns_msel_wr_a: assert property (wr_st && ns_hit && off == 13'h800
    ##1 pready |=> ns_mon_sel == $past(wd2) && $stable(s_mon_sel))
    else $error("ns monitor select write");
  sel_cause_a: assert property (($changed(s_part_sel) ||
    $changed(ns_part_sel)) && $past(rst_n) |-> $past(wr_end))
    else $error("selector moved without a write");

  // main scenarios
  cov_write_c: cover property (wr_st ##1 pready);
  cov_err_c: cover property (setup && !hit ##1 pslverr);
  cov_s_read_c: cover property (rd_st && s_hit);
endmodule

// [dv/tb_pmpd_page_decode.sv]
// directed bench for the feature page decoder over apb.
// assumes the decoder with default page bases and the map header.
`timescale 1ns/1ns
`include "pmpd_map.vh"

module tb_pmpd_page_decode;
  localparam [31:0] NSB = `PMPD_NS_BASE;  // ns page base
  localparam [31:0] SB  = `PMPD_S_BASE;   // secure page base
  localparam [2:0]  PN  = 3'h2;           // ns access attribute
  localparam [2:0]  PS  = 3'h0;           // secure access attribute
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [2:0]  pprot = 3'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] pwdata = 32'h0;
  logic        ev_valid = 1'b0;
  logic        ev_ns = 1'b0;
  logic [3:0]  ev_partition_identifier = 4'h0;
  logic        lk_ns = 1'b0;
  logic [3:0]  lk_partition_identifier = 4'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [15:0] lk_cpbm;
  wire  [3:0]  s_part_sel;
  wire  [3:0]  ns_part_sel;
  wire  [1:0]  s_mon_sel;
  wire  [1:0]  ns_mon_sel;
  int          errors = 0;      // mismatches
  int          n_compared = 0;  // comparisons
  logic [31:0] rdv;             // last read data
  logic        erv;             // last error flag

  pmpd_page_decode pmpd_page_decode_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pprot(pprot), .pstrb(pstrb),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev_valid(ev_valid), .ev_ns(ev_ns),
    .ev_partition_identifier(ev_partition_identifier), .lk_ns(lk_ns), .lk_partition_identifier(lk_partition_identifier),
    .lk_cpbm(lk_cpbm), .s_part_sel(s_part_sel),
    .ns_part_sel(ns_part_sel), .s_mon_sel(s_mon_sel),
    .ns_mon_sel(ns_mon_sel));

  // 100 mhz clock
  always #5 clk = ~clk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t saw %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits for ready under a bounded count
  task xf(input logic w, input logic [31:0] a, input logic [31:0] d,
          input logic [2:0] pr, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= pr;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) errors++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] pr);
    xf(1'b1, a, d, pr, 4'hf);
  endtask

  task rc(input logic [31:0] a, input logic [2:0] pr, input logic [31:0] e);
    xf(1'b0, a, 32'h0, pr, 4'hf);
    chk(rdv, e);
  endtask

  // one usage event pulse
  task ev(input logic n, input logic [3:0] p);
    @(posedge clk);
    ev_valid <= 1'b1;
    ev_ns <= n;
    ev_partition_identifier <= p;
    @(posedge clk);
    ev_valid <= 1'b0;
  endtask

  // reset values, main and secure id in both pages, other id registers in the ns page
  task t_id;
    chk(ns_part_sel, 32'h0);
    chk(lk_cpbm, 32'hffff);
    rc(NSB, PN, 32'h4203000f);
    rc(SB, PS, 32'h4203000f);
    rc(NSB + 32'h30, PN, 32'h00000010);
    rc(NSB + 32'h80, PN, 32'h00010000);
    rc(NSB + 32'h88, PN, 32'h00000004);
    rc(SB + 32'h8, PS, 32'h0003000f);
    rc(NSB + 32'h8, PN, 32'h0);
    wr(NSB, 32'h0, PN);
    rc(NSB, PN, 32'h4203000f);
    $display("test id done at %0t", $time);
  endtask

  // banked selectors, partial and misaligned writes
  task t_sel;
    wr(SB + 32'h100, 32'h5, PS);
    wr(NSB + 32'h100, 32'hfffffffa, PN);
    rc(SB + 32'h100, PS, 32'h5);
    rc(NSB + 32'h100, PN, 32'ha);
    chk(s_part_sel, 32'h5);
    wr(SB + 32'h800, 32'h3, PS);
    wr(NSB + 32'h800, 32'h6, PN);
    rc(SB + 32'h800, PS, 32'h3);
    rc(NSB + 32'h800, PN, 32'h2);
    chk(s_mon_sel, 32'h3);
    chk(ns_mon_sel, 32'h2);
    xf(1'b1, SB + 32'h100, 32'h9, PS, 4'h3);
    xf(1'b1, SB + 32'h102, 32'h9, PS, 4'hf);
    rc(SB + 32'h100, PS, 32'h5);
    $display("test sel done at %0t", $time);
  endtask

  // portion bitmap follows the selected partition
  task t_cpbm;
    wr(NSB + 32'h100, 32'h2, PN);
    wr(NSB + 32'h1000, 32'h00f0, PN);
    wr(NSB + 32'h100, 32'h3, PN);
    rc(NSB + 32'h1000, PN, 32'hffff);
    wr(NSB + 32'h100, 32'h2, PN);
    rc(NSB + 32'h1000, PN, 32'h00f0);
    wr(SB + 32'h100, 32'h2, PS);
    rc(SB + 32'h1000, PS, 32'hffff);
    @(posedge clk);
    lk_ns <= 1'b1;
    lk_partition_identifier <= 4'h2;
    repeat (2) @(posedge clk);
    chk(lk_cpbm, 32'h00f0);
    lk_ns <= 1'b0;
    repeat (2) @(posedge clk);
    chk(lk_cpbm, 32'hffff);
    $display("test bitmap done at %0t", $time);
  endtask

  // monitor instance routing and counting
  task t_mon;
    wr(NSB + 32'h800, 32'h1, PN);
    wr(NSB + 32'h818, 32'h4, PN);
    wr(NSB + 32'h840, 32'h0, PN);
    wr(NSB + 32'h810, 32'h80000000, PN);
    ev(1'b1, 4'h4);
    ev(1'b1, 4'h4);
    ev(1'b1, 4'h5);
    ev(1'b0, 4'h4);
    ev(1'b1, 4'h4);
    rc(NSB + 32'h840, PN, 32'h3);
    wr(NSB + 32'h800, 32'h0, PN);
    rc(NSB + 32'h840, PN, 32'h0);
    rc(SB + 32'h840, PS, 32'h0);
    $display("test monitor done at %0t", $time);
  endtask

  // outside pages, wrong space, reserved offset
  task t_err;
    xf(1'b0, NSB + 32'h2000, 32'h0, PN, 4'hf);
    chk(erv, 32'h1);
    chk(rdv, 32'h0);
    xf(1'b1, SB + 32'h100, 32'h7, PN, 4'hf);
    chk(erv, 32'h1);
    chk(s_part_sel, 32'h2);
    rc(NSB + 32'h200, PN, 32'h0);
    chk(erv, 32'h0);
    $display("test errors done at %0t", $time);
  endtask

  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_id;
    t_sel;
    t_cpbm;
    t_mon;
    t_err;
    wrap_up;
  end

  // hang guard, well beyond the expected run
  initial begin
    #50000;
    errors++;
    wrap_up;
  end
endmodule

bind pmpd_page_decode pmpd_props_chk #(
  .NS_PAGE_BASE(NS_PAGE_BASE), .S_PAGE_BASE(S_PAGE_BASE)
) pmpd_props_chk_i (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pprot(pprot), .pstrb(pstrb),
  .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .s_part_sel(s_part_sel),
  .ns_part_sel(ns_part_sel), .s_mon_sel(s_mon_sel),
  .ns_mon_sel(ns_mon_sel));
